// File: rtl/adc_cfg_pkg.sv
// Shared definitions for the converter configuration register slice.
// Assumes a 32-bit classic Wishbone slave port and a single 40 MHz clock.
package adc_cfg_pkg;

    // Bus widths.
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADR_W = 8;
    localparam int unsigned IDX_W = 6;
    localparam int unsigned IDX_LSB = 2;

    // Register indices; the byte address is four times the index.
    localparam logic [IDX_W-1:0] IDX_CLOCK = 6'h03;
    localparam logic [IDX_W-1:0] IDX_GAIN_LO = 6'h04;
    localparam logic [IDX_W-1:0] IDX_GAIN_HI = 6'h05;
    localparam logic [IDX_W-1:0] IDX_STATUS = 6'h06;
    localparam logic [IDX_W-1:0] IDX_GAIN_VAL = 6'h07;

    // Field positions in the clock configuration register.
    localparam int unsigned CLK_XTAL_BIT = 7;
    localparam int unsigned CLK_EXTREF_BIT = 6;
    localparam int unsigned CLK_SPARE_BIT = 5;
    localparam int unsigned CLK_OSR_LSB = 2;
    localparam int unsigned CLK_OSR_W = 3;
    localparam int unsigned CLK_PWR_LSB = 0;
    localparam int unsigned CLK_PWR_W = 2;
    localparam int unsigned CLK_LO_W = 8;

    // Field positions in the gain registers.
    localparam int unsigned GAIN_W = 16;
    localparam int unsigned GAIN_CODE_W = 3;
    localparam int unsigned GAIN_STRIDE = 4;
    localparam int unsigned GAIN_CH = 4;
    localparam int unsigned GAIN_VAL_W = 8;

    // Field positions in the status register.
    localparam int unsigned STAT_RATIO_LSB = 0;
    localparam int unsigned STAT_MODE_LSB = 16;

    // Reset values.
    localparam logic [CLK_LO_W-1:0] CLOCK_LO_RESET = 8'h0e;
    localparam logic [GAIN_W-1:0] GAIN_LO_RESET = 16'h0000;
    localparam logic [GAIN_W-1:0] GAIN_HI_RESET = 16'h0000;

    // Oversampling ratio decode.
    localparam int unsigned RATIO_W = 14;
    localparam logic [RATIO_W-1:0] OSR_BASE = 14'h0080;
    localparam logic [CLK_OSR_W-1:0] OSR_TOP_CODE = 3'h7;
    localparam logic [RATIO_W-1:0] OSR_TOP_RATIO = 14'h3f80;

    // Power mode codes.
    localparam logic [CLK_PWR_W-1:0] PWR_CODE_VLP = 2'h0;
    localparam logic [CLK_PWR_W-1:0] PWR_CODE_LP = 2'h1;

    // Amplifier gain of code zero.
    localparam logic [GAIN_VAL_W-1:0] GAIN_UNITY = 8'h01;

    typedef enum logic [1:0] {
        PWR_VERY_LOW,
        PWR_LOW,
        PWR_HIGH_RES
    } power_mode_type;

    typedef enum logic {
        BUS_IDLE,
        BUS_ACK
    } bus_state_type;

    // Clock register low half, laid out as the register bits.
    typedef struct packed {
        logic crystal_osc_off;
        logic external_vref_select;
        logic spare;
        logic [CLK_OSR_W-1:0] oversample_ratio_code;
        logic [CLK_PWR_W-1:0] power_level_select;
    } clock_cfg_type;

    // First gain register, laid out as the register bits.
    typedef struct packed {
        logic spare15;
        logic [GAIN_CODE_W-1:0] amp_gain_code_ch3;
        logic spare11;
        logic [GAIN_CODE_W-1:0] amp_gain_code_ch2;
        logic spare7;
        logic [GAIN_CODE_W-1:0] amp_gain_code_ch1;
        logic spare3;
        logic [GAIN_CODE_W-1:0] amp_gain_code_ch0;
    } gain_lo_type;

    // Decoded settings handed to the analog side.
    typedef struct packed {
        logic [RATIO_W-1:0] ratio;
        power_mode_type power_mode;
        logic [GAIN_CH-1:0][GAIN_VAL_W-1:0] gain_val;
    } decoded_type;

endpackage : adc_cfg_pkg

// File: rtl/amp_gain_decode.sv
// Decoder from one 3-bit amplifier gain code to its gain factor.
// Assumes the caller registers the result.
`timescale 1ns/100ps
module amp_gain_decode
    import adc_cfg_pkg::*;
(
    input wire logic [GAIN_CODE_W-1:0] code_i,
    output logic [GAIN_VAL_W-1:0] gain_o
);

    // The gain is two raised to the code, so code 7 gives 128.
    always_comb begin
        gain_o = GAIN_UNITY << code_i;
    end

endmodule : amp_gain_decode

// File: rtl/osr_power_decode.sv
// Decoder for the oversampling ratio and power mode fields.
// Assumes the caller registers the results.
`timescale 1ns/100ps
module osr_power_decode
    import adc_cfg_pkg::*;
(
    input wire logic [CLK_OSR_W-1:0] osr_code_i,
    input wire logic [CLK_PWR_W-1:0] pwr_code_i,
    output logic [RATIO_W-1:0] ratio_o,
    output power_mode_type mode_o
);

    // Ratios double from 128 per code, except the top code.
    always_comb begin
        if (osr_code_i == OSR_TOP_CODE) begin
            ratio_o = OSR_TOP_RATIO;
        end else begin
            ratio_o = OSR_BASE << osr_code_i;
        end
    end

    // Both upper power codes select high resolution.
    always_comb begin
        case (pwr_code_i)
            PWR_CODE_VLP: mode_o = PWR_VERY_LOW;
            PWR_CODE_LP: mode_o = PWR_LOW;
            default: mode_o = PWR_HIGH_RES;
        endcase
    end

endmodule : osr_power_decode

// File: rtl/adc_clock_gain_config_regs.sv
// Configuration register slice: clock register low half and two gain
// registers, reached as a classic Wishbone slave.
// Assumes one clock, a synchronous active-high reset and a master that
// holds its request until it sees ack.
//
// Register map, by word index; the byte address is four times the index.
//   Index 3 holds the clock register low half: oscillator, reference,
//   oversampling ratio code and power level.
//   Index 4 holds the first gain register, amplifier codes for channels
//   0 to 3, and index 5 the second gain register as plain storage.
//   Index 6 reads back the decoded ratio in bits 13:0 and the power mode
//   in bits 17:16; index 7 reads the decoded gains, one byte a channel.
// Any other index is acknowledged, reads zero and drops its writes.
// Only byte lanes 0 and 1 carry write data; lanes 2 and 3 are ignored on writes.
//
// A request is taken at the first rising edge that sees cyc and stb high
// while ack is low. The addressed register and every decoded output change
// at that edge; ack and the read data then stand for one cycle. A master
// that keeps stb high after ack will have its request taken again.
// Reserved bits are stored as written and feed no decoder, so software is
// expected to write them as zero.
//
// The slice holds no counters and no flags set by hardware; every bit of
// state is written by software or by reset. The clock register upper half,
// with its channel enables, lives outside this slice.
`timescale 1ns/100ps
module adc_clock_gain_config_regs
    import adc_cfg_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [ADR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [DATA_W-1:0] dat_i,
    output logic [DATA_W-1:0] dat_o,
    output logic ack_o,
    output logic crystal_osc_off_o,
    output logic external_vref_select_o,
    output logic [CLK_OSR_W-1:0] oversample_ratio_code_o,
    output logic [CLK_PWR_W-1:0] power_level_select_o,
    output logic [RATIO_W-1:0] oversample_ratio_o,
    output power_mode_type power_mode_o,
    output gain_lo_type gain_ch0_to_ch3_o,
    output logic [GAIN_W-1:0] gain_ch4_to_ch7_o,
    output logic [GAIN_CH-1:0][GAIN_VAL_W-1:0] amp_gain_o
);

    // Whole state of the slice in one record: the bus handshake, the read
    // data being returned, the three stored registers and the decoded
    // settings. Keeping the decodes registered means every output of the
    // slice comes straight from a flip-flop, at the price of one extra
    // copy of the ratio, the power mode and the four gains.
    typedef struct packed {
        bus_state_type bus_state;
        logic [DATA_W-1:0] rdata;
        clock_cfg_type clock_cfg;
        gain_lo_type gain_lo;
        logic [GAIN_W-1:0] gain_hi;
        decoded_type decoded;
    } state_type;

    // Present state, and its next value from the combinational logic.
    state_type state_q;
    state_type state_d;

    // Bus side: decoded index, accepted request and write strobes.
    logic [IDX_W-1:0] reg_idx;
    logic request;
    logic wr_clock;
    logic wr_gain_lo;
    logic wr_gain_hi;

    // Byte-lane mask built from the byte selects.
    logic [DATA_W-1:0] byte_mask;

    // Register contents after this cycle's write, if any.
    clock_cfg_type clock_next;
    gain_lo_type gain_lo_next;
    logic [GAIN_W-1:0] gain_hi_next;

    // Decodes of the next register contents.
    logic [RATIO_W-1:0] ratio_next;
    power_mode_type mode_next;
    logic [GAIN_CH-1:0][GAIN_CODE_W-1:0] gain_code_next;
    logic [GAIN_CH-1:0][GAIN_VAL_W-1:0] gain_val_next;

    // Read data selected by the index.
    logic [DATA_W-1:0] read_mux;

    // Address decode: the word index, with the byte offset bits ignored.
    // Every address bit above the byte offset takes part, so an index outside the map
    // simply falls through to the default arm of the read mux below.
    assign reg_idx = adr_i[ADR_W-1:IDX_LSB];

    // A request is accepted only from the idle state. The ack cycle sits
    // between two acceptances, so the write strobes below fire once per
    // access even though the master still holds its request while it
    // waits for ack. A master that holds stb past ack starts a new access.
    assign request = cyc_i && stb_i && (state_q.bus_state == BUS_IDLE);

    // Write strobes, one per stored register. The status and decoded-gain
    // words have no strobe, so writes to them are acknowledged and lost.
    assign wr_clock = request && we_i && (reg_idx == IDX_CLOCK);
    assign wr_gain_lo = request && we_i && (reg_idx == IDX_GAIN_LO);
    assign wr_gain_hi = request && we_i && (reg_idx == IDX_GAIN_HI);

    // Expand byte selects into a bit mask. Only lanes 0 and 1 reach a
    // register, since no register here is wider than sixteen bits; the
    // upper lanes are built anyway so the mask lines up with the data bus.
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            byte_mask[b*8 +: 8] = {8{sel_i[b]}};
        end
    end

    // Next register contents, merged lane by lane with the stored value.
    // Reserved bits are kept as written; software is expected to write
    // zeros there, so they hold no meaning for the slice itself.
    // A write to the clock register with lane 0 off changes nothing, and
    // a write to an index outside the map raises no strobe at all, so the
    // stored values carry over unchanged.
    always_comb begin
        clock_next = state_q.clock_cfg;
        gain_lo_next = state_q.gain_lo;
        gain_hi_next = state_q.gain_hi;
        if (wr_clock) begin
            clock_next = clock_cfg_type'((dat_i[CLK_LO_W-1:0]
                & byte_mask[CLK_LO_W-1:0])
                | (state_q.clock_cfg & ~byte_mask[CLK_LO_W-1:0]));
        end
        if (wr_gain_lo) begin
            gain_lo_next = gain_lo_type'((dat_i[GAIN_W-1:0]
                & byte_mask[GAIN_W-1:0])
                | (state_q.gain_lo & ~byte_mask[GAIN_W-1:0]));
        end
        if (wr_gain_hi) begin
            gain_hi_next = (dat_i[GAIN_W-1:0] & byte_mask[GAIN_W-1:0])
                | (state_q.gain_hi & ~byte_mask[GAIN_W-1:0]);
        end
    end

    // Channel gain codes, taken from the next first gain register so that
    // the decoded gains change at the same edge as the raw register.
    // Each code is three bits wide; the spare bit above it is not used.
    assign gain_code_next[0] = gain_lo_next.amp_gain_code_ch0;
    assign gain_code_next[1] = gain_lo_next.amp_gain_code_ch1;
    assign gain_code_next[2] = gain_lo_next.amp_gain_code_ch2;
    assign gain_code_next[3] = gain_lo_next.amp_gain_code_ch3;

    // One gain decoder per channel of the first gain register. The second
    // gain register has no decode here; its channels are handled elsewhere.
    genvar ch;
    generate
        for (ch = 0; ch < GAIN_CH; ch++) begin : g_gain
            amp_gain_decode u_gain (
                .code_i(gain_code_next[ch]),
                .gain_o(gain_val_next[ch])
            );
        end
    endgenerate

    // Ratio and power mode decode from the next clock settings, again so
    // that a write and its decode become visible on the same edge.
    // The top ratio code does not double; the decoder handles it apart.
    osr_power_decode u_osr (
        .osr_code_i(clock_next.oversample_ratio_code),
        .pwr_code_i(clock_next.power_level_select),
        .ratio_o(ratio_next),
        .mode_o(mode_next)
    );

    // Read data for the addressed register; unmapped words read zero.
    // The mux looks at the stored values, not the next ones; a read is
    // never combined with a write in one access, so both agree anyway.
    // Bits above a register's width read zero because the mux starts
    // from zero on every path.
    always_comb begin
        read_mux = '0;
        case (reg_idx)
            // Clock register low half; its upper byte reads zero.
            IDX_CLOCK: begin
                read_mux[CLK_LO_W-1:0] = state_q.clock_cfg;
            end
            // First gain register, reserved bits included.
            IDX_GAIN_LO: begin
                read_mux[GAIN_W-1:0] = state_q.gain_lo;
            end
            // Second gain register, stored as written.
            IDX_GAIN_HI: begin
                read_mux[GAIN_W-1:0] = state_q.gain_hi;
            end
            // Decoded ratio and power mode, read only.
            IDX_STATUS: begin
                read_mux[STAT_RATIO_LSB +: RATIO_W] =
                    state_q.decoded.ratio;
                read_mux[STAT_MODE_LSB +: 2] =
                    state_q.decoded.power_mode;
            end
            // Decoded gains, byte n for channel n, read only.
            IDX_GAIN_VAL: begin
                read_mux = state_q.decoded.gain_val;
            end
            // Indices outside the map.
            default: begin
                read_mux = '0;
            end
        endcase
    end

    // Next state: bus handshake, register updates and decoded outputs.
    // The registers and decodes follow their next values every cycle; the
    // handshake moves from idle to ack on an accepted request and back to
    // idle after one cycle, clearing the read data on the way. Reset is
    // applied last so that it overrides any request seen in the same cycle.
    always_comb begin
        state_d = state_q;
        state_d.clock_cfg = clock_next;
        state_d.gain_lo = gain_lo_next;
        state_d.gain_hi = gain_hi_next;
        state_d.decoded.ratio = ratio_next;
        state_d.decoded.power_mode = mode_next;
        state_d.decoded.gain_val = gain_val_next;
        case (state_q.bus_state)
            BUS_IDLE: begin
                // Reads latch the mux now, so the data stand with ack;
                // writes return zero data.
                if (request) begin
                    state_d.bus_state = BUS_ACK;
                    state_d.rdata = we_i ? '0 : read_mux;
                end
            end
            BUS_ACK: begin
                // Ack stands one cycle; the master then releases.
                state_d.bus_state = BUS_IDLE;
                state_d.rdata = '0;
            end
            default: begin
                state_d.bus_state = BUS_IDLE;
            end
        endcase
        // Reset values: oscillator on, internal reference, ratio code 3
        // (1024), high-resolution power, all gain codes zero (gain 1). The
        // decodes are loaded with the matching values so that no output
        // shows a stale decode in the first cycle after reset.
        if (rst_i) begin
            state_d.bus_state = BUS_IDLE;
            state_d.rdata = '0;
            state_d.clock_cfg = clock_cfg_type'(CLOCK_LO_RESET);
            state_d.gain_lo = gain_lo_type'(GAIN_LO_RESET);
            state_d.gain_hi = GAIN_HI_RESET;
            state_d.decoded.ratio = OSR_BASE << CLOCK_LO_RESET[
                CLK_OSR_LSB +: CLK_OSR_W];
            state_d.decoded.power_mode = PWR_HIGH_RES;
            state_d.decoded.gain_val = {GAIN_CH{GAIN_UNITY}};
        end
    end

    // State register; reset is applied through the next-state logic, so
    // this is the only clocked process and the only place state is held.
    always_ff @(posedge clk_i) begin
        state_q <= state_d;
    end

    // Outputs straight from the state flip-flops; none passes through
    // logic after the register, so none can glitch.
    // Bus answer: read data and a one-cycle acknowledge.
    assign dat_o = state_q.rdata;
    assign ack_o = (state_q.bus_state == BUS_ACK);

    // Raw clock register fields.
    assign crystal_osc_off_o = state_q.clock_cfg.crystal_osc_off;
    assign external_vref_select_o =
        state_q.clock_cfg.external_vref_select;
    assign oversample_ratio_code_o =
        state_q.clock_cfg.oversample_ratio_code;
    assign power_level_select_o =
        state_q.clock_cfg.power_level_select;

    // Decoded ratio and power mode.
    assign oversample_ratio_o = state_q.decoded.ratio;
    assign power_mode_o = state_q.decoded.power_mode;

    // Raw gain registers and the decoded gains of channels 0 to 3.
    assign gain_ch0_to_ch3_o = state_q.gain_lo;
    assign gain_ch4_to_ch7_o = state_q.gain_hi;
    assign amp_gain_o = state_q.decoded.gain_val;

endmodule : adc_clock_gain_config_regs

// File: test/cfg_regs_asserts.sv
// Checker for the configuration register slice, bound to its ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
module cfg_regs_checker
    import adc_cfg_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [ADR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [DATA_W-1:0] dat_i,
    input wire logic [DATA_W-1:0] dat_o,
    input wire logic ack_o,
    input wire logic crystal_osc_off_o,
    input wire logic external_vref_select_o,
    input wire logic [CLK_OSR_W-1:0] oversample_ratio_code_o,
    input wire logic [CLK_PWR_W-1:0] power_level_select_o,
    input wire logic [RATIO_W-1:0] oversample_ratio_o,
    input wire power_mode_type power_mode_o,
    input wire gain_lo_type gain_ch0_to_ch3_o,
    input wire logic [GAIN_W-1:0] gain_ch4_to_ch7_o,
    input wire logic [GAIN_CH-1:0][GAIN_VAL_W-1:0] amp_gain_o
);
    logic req_take, wr_take;
    gain_lo_type g;

    // Requests the slice takes, and writes among them.
    assign req_take = cyc_i && stb_i && !ack_o;
    assign wr_take = req_take && we_i;
    assign g = gain_ch0_to_ch3_o;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ack_follows_req_a: assert property (req_take |=> ack_o)
        else $error("request not acknowledged next cycle");
    ack_single_a: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    clock_write_a: assert property (
        wr_take && sel_i[0] && adr_i[7:2] == IDX_CLOCK |=>
        {crystal_osc_off_o, external_vref_select_o} == $past(dat_i[7:6]))
        else $error("clock register write not seen on outputs");
    osr_decode_a: assert property (oversample_ratio_o ==
        ((oversample_ratio_code_o == 3'h7) ? 14'h3f80 :
        14'h0080 << oversample_ratio_code_o))
        else $error("oversampling ratio decode wrong");
    power_decode_a: assert property (power_mode_o ==
        (power_level_select_o == 2'h0 ? PWR_VERY_LOW :
        power_level_select_o == 2'h1 ? PWR_LOW : PWR_HIGH_RES))
        else $error("power mode decode wrong");
    gain_decode_a: assert property (
        amp_gain_o[0] == 8'h01 << g.amp_gain_code_ch0 &&
        amp_gain_o[1] == 8'h01 << g.amp_gain_code_ch1 &&
        amp_gain_o[2] == 8'h01 << g.amp_gain_code_ch2 &&
        amp_gain_o[3] == 8'h01 << g.amp_gain_code_ch3)
        else $error("amplifier gain decode wrong");
    gain_write_a: assert property (
        wr_take && sel_i[1:0] == 2'h3 && adr_i[7:2] == IDX_GAIN_LO |=>
        gain_ch0_to_ch3_o == $past(dat_i[15:0]))
        else $error("first gain register write lost");
    regs_hold_a: assert property (!wr_take |=>
        $stable(gain_ch0_to_ch3_o) && $stable(gain_ch4_to_ch7_o) &&
        $stable(oversample_ratio_code_o))
        else $error("register changed without a write");
endmodule : cfg_regs_checker

bind adc_clock_gain_config_regs cfg_regs_checker chk (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .crystal_osc_off_o(crystal_osc_off_o),
    .external_vref_select_o(external_vref_select_o),
    .oversample_ratio_code_o(oversample_ratio_code_o),
    .power_level_select_o(power_level_select_o),
    .oversample_ratio_o(oversample_ratio_o), .power_mode_o(power_mode_o),
    .gain_ch0_to_ch3_o(gain_ch0_to_ch3_o),
    .gain_ch4_to_ch7_o(gain_ch4_to_ch7_o), .amp_gain_o(amp_gain_o)
);

// File: test/testbench.sv
// Self-checking bench for the configuration register slice.
// Assumes a one-cycle Wishbone ack and a 40 MHz clock.
`timescale 1ns/100ps
module testbench;
    import adc_cfg_pkg::*;
    logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, xo, ev, rw;
    logic [7:0] adr_i, cm;
    logic [3:0] sel_i;
    logic [31:0] dat_i, dat_o, rd;
    logic [2:0] oc;
    logic [1:0] pc;
    logic [13:0] ratio;
    logic [5:0] ri;
    power_mode_type pm;
    gain_lo_type glo;
    logic [15:0] ghi, gm_lo, gm_hi;
    logic [3:0][7:0] amp;
    int fails, num_checks;

    adc_clock_gain_config_regs dut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .crystal_osc_off_o(xo),
        .external_vref_select_o(ev), .oversample_ratio_code_o(oc),
        .power_level_select_o(pc), .oversample_ratio_o(ratio),
        .power_mode_o(pm), .gain_ch0_to_ch3_o(glo),
        .gain_ch4_to_ch7_o(ghi), .amp_gain_o(amp)
    );

    // Expected decodes, worked out from the field tables.
    function automatic logic [13:0] ratio_of(logic [2:0] c);
        return (c == 3'h7) ? 14'h3f80 : 14'h0080 << c;
    endfunction : ratio_of
    function automatic logic [1:0] mode_of(logic [1:0] p);
        return p[1] ? 2'h2 : {1'b0, p[0]};
    endfunction : mode_of
    function automatic logic [31:0] gains_of(logic [15:0] g);
        return {8'h01 << g[14:12], 8'h01 << g[10:8],
                8'h01 << g[6:4], 8'h01 << g[2:0]};
    endfunction : gains_of
    function automatic logic [15:0] merge(logic [15:0] o, logic [3:0] s,
                                          logic [15:0] d);
        return {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
    endfunction : merge
    function automatic logic [31:0] exp_rd(logic [5:0] i);
        case (i)
            6'h03: return {24'h0, cm};
            6'h04: return {16'h0, gm_lo};
            6'h05: return {16'h0, gm_hi};
            6'h06: return {14'h0, mode_of(cm[1:0]), 2'h0, ratio_of(cm[4:2])};
            6'h07: return gains_of(gm_lo);
            default: return 32'h0;
        endcase
    endfunction : exp_rd

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test

    // Compares one value and counts the outcome.
    task automatic check(string name, logic [31:0] exp, logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // One classic cycle; the model follows writes, reads are compared.
    task automatic bus(logic w, logic [5:0] i, logic [3:0] s, logic [31:0] d);
        int n;
        @(posedge clk_i);
        check("idle ack", 32'h0, {31'h0, ack_o});
        check("idle data", 32'h0, dat_o);
        {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'h3, w, i, 2'h0, s, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        rd = dat_o;
        {cyc_i, stb_i} <= 2'h0;
        if (!w) check("read data", exp_rd(i), rd);
        if (w && i == 6'h03 && s[0]) cm = d[7:0];
        if (w && i == 6'h04) gm_lo = merge(gm_lo, s, d[15:0]);
        if (w && i == 6'h05) gm_hi = merge(gm_hi, s, d[15:0]);
        if (ack_o !== 1'b1) begin
            fails++;
            stop_test();
        end
    endtask : bus

    // Compares every configuration output against the model.
    task automatic check_outs();
        check("clock", {cm[7:6], cm[4:0]}, {xo, ev, oc, pc});
        check("ratio", ratio_of(cm[4:2]), ratio);
        check("mode", mode_of(cm[1:0]), pm);
        check("gain_lo", gm_lo, glo);
        check("gain_hi", gm_hi, ghi);
        check("amp", gains_of(gm_lo), amp);
    endtask : check_outs

    // Free-running 40 MHz clock.
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // Reset, code sweeps, lane and unmapped cases, random traffic, reset.
    initial begin
        {rst_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {1'b1, 47'h0};
        fails = 0;
        num_checks = 0;
        {cm, gm_lo, gm_hi} = {8'h0e, 32'h0};
        void'($urandom(32'hcfe8e4c6));
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check_outs();
        for (int i = 3; i < 8; i++) bus(1'b0, 6'(i), 4'hf, 32'h0);
        for (int k = 0; k < 8; k++) begin
            bus(1'b1, 6'h03, 4'h1,
                {24'h0, k[0], k[1], 1'b0, 3'(k), k[1:0]});
            bus(1'b1, 6'h04, 4'h3, {17'h0, 3'(k + 3), 1'b0, 3'(k + 2),
                1'b0, 3'(k + 1), 1'b0, 3'(k)});
            check_outs();
            bus(1'b0, 6'h06, 4'hf, 32'h0);
        end
        bus(1'b1, 6'h04, 4'h2, 32'h0000_5070);
        bus(1'b1, 6'h05, 4'hc, 32'h7777_0000);
        bus(1'b1, 6'h3f, 4'hf, 32'h0000_0077);
        bus(1'b0, 6'h3f, 4'hf, 32'h0);
        check_outs();
        for (int k = 0; k < 80; k++) begin
            ri = 6'($urandom_range(0, 7));
            rw = ri < 6'h06 && $urandom_range(0, 1) == 1;
            bus(rw, ri, 4'($urandom), $urandom &
                (ri == 6'h03 ? 32'h0000_00df : 32'h0000_7777));
            check_outs();
        end
        rst_i <= 1'b1;
        @(posedge clk_i);
        rst_i <= 1'b0;
        {cm, gm_lo, gm_hi} = {8'h0e, 32'h0};
        @(posedge clk_i);
        check_outs();
        stop_test();
    end
endmodule : testbench
